// ---- bench/tb.sv ----
// self-checking bench for comparator_control over apb
`timescale 1ns/100ps
module tb;
  import comparator_ctrl_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata;
  logic pready, pslverr, comparator_power_off, bandgap_positive_select;
  logic negative_use_channel, capture_trigger, comparator_irq;
  logic [2:0] negative_channel;
  logic comparator_raw = 1'b0;
  logic global_irq_enable = 1'b0;
  logic irq_vector_ack = 1'b0;
  int err_total = 0;
  int cmp_count = 0;
  int cycles = 0;

  comparator_control u_comparator_control (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .comparator_raw(comparator_raw), .global_irq_enable(global_irq_enable),
    .irq_vector_ack(irq_vector_ack),
    .comparator_power_off(comparator_power_off),
    .bandgap_positive_select(bandgap_positive_select),
    .negative_use_channel(negative_use_channel),
    .negative_channel(negative_channel), .capture_trigger(capture_trigger),
    .comparator_irq(comparator_irq));

  always #4 pclk = ~pclk;

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up

  // a hang in the handshake ends the run here
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      err_total++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic chk_pin(input logic got, input logic exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: pin %s got %b", $time, msg, got);
    end
  endtask : chk_pin

  // master waits for pready itself, no fixed latency assumed
  task automatic apb(input logic wr_en, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, {24'h000000, d}, q, e);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] exp,
                    input logic expe);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h00000000, q, e);
    chk(q, {24'h000000, exp}, "read data");
    chk({31'h0, e}, {31'h0, expe}, "slave error");
  endtask : rd

  // raw change needs three edges to reach the flag, five leaves margin
  task automatic raw_to(input logic v);
    @(posedge pclk);
    comparator_raw <= v;
    repeat (5) @(posedge pclk);
  endtask : raw_to

  task automatic test_reset;
    rd(CSR_OFFSET, CSR_RESET, 1'b0);
    rd(CTRL_B_OFFSET, CTRL_B_RESET, 1'b0);
    rd(MUX_OFFSET, MUX_RESET, 1'b0);
    rd(CTRL_A_OFFSET, CTRL_A_RESET, 1'b0);
    wr(12'h010, 8'hff);
    rd(12'h010, 8'h00, 1'b1);
    rd(CSR_OFFSET, 8'h00, 1'b0);
    chk_pin(comparator_irq, 1'b0, "irq");
    $display("test reset done");
  endtask : test_reset

  task automatic test_power;
    wr(CSR_OFFSET, 8'hc0);
    repeat (2) @(posedge pclk);
    chk_pin(comparator_power_off, 1'b1, "power off");
    chk_pin(bandgap_positive_select, 1'b1, "bandgap");
    rd(CSR_OFFSET, 8'hc0, 1'b0);
    wr(CSR_OFFSET, 8'h40);
    repeat (2) @(posedge pclk);
    chk_pin(comparator_power_off, 1'b0, "power on");
    wr(CSR_OFFSET, 8'h00);
    repeat (2) @(posedge pclk);
    chk_pin(bandgap_positive_select, 1'b0, "pin input");
    $display("test power done");
  endtask : test_power

  task automatic test_mux;
    // power reduction is not modelled, so it is taken as held at zero
    wr(CTRL_B_OFFSET, 8'h40);
    rd(CTRL_B_OFFSET, 8'h40, 1'b0);
    for (int c = 0; c < 8; c++) begin
      wr(MUX_OFFSET, 8'(c));
      repeat (2) @(posedge pclk);
      chk_pin(negative_use_channel, 1'b1, "use channel");
      chk({29'h0, negative_channel}, 32'(c), "channel");
    end
    wr(CTRL_A_OFFSET, 8'h80);
    repeat (2) @(posedge pclk);
    chk_pin(negative_use_channel, 1'b0, "converter on");
    wr(CTRL_A_OFFSET, 8'h00);
    wr(CTRL_B_OFFSET, 8'h00);
    repeat (2) @(posedge pclk);
    chk_pin(negative_use_channel, 1'b0, "mux off");
    $display("test mux done");
  endtask : test_mux

  // irq enable stays clear while the mode changes
  task automatic test_modes;
    logic [7:0] m;
    for (int i = 0; i < 4; i++) begin
      m = 8'(i);
      wr(CSR_OFFSET, 8'h10 | m);
      raw_to(1'b1);
      rd(CSR_OFFSET, 8'h20 | ((i == 0 || i == 3) ? 8'h10 : 8'h00) | m,
         1'b0);
      wr(CSR_OFFSET, 8'h10 | m);
      raw_to(1'b0);
      rd(CSR_OFFSET, ((i == 0 || i == 2) ? 8'h10 : 8'h00) | m,
         1'b0);
    end
    $display("test modes done");
  endtask : test_modes

  task automatic test_clear;
    wr(CSR_OFFSET, 8'h13);
    raw_to(1'b1);
    wr(CSR_OFFSET, 8'h03);
    rd(CSR_OFFSET, 8'h33, 1'b0);
    @(posedge pclk);
    irq_vector_ack <= 1'b1;
    @(posedge pclk);
    irq_vector_ack <= 1'b0;
    repeat (2) @(posedge pclk);
    rd(CSR_OFFSET, 8'h23, 1'b0);
    raw_to(1'b0);
    $display("test clear done");
  endtask : test_clear

  task automatic test_irq;
    global_irq_enable <= 1'b1;
    wr(CSR_OFFSET, 8'h0b);
    raw_to(1'b1);
    chk_pin(comparator_irq, 1'b1, "irq raised");
    global_irq_enable <= 1'b0;
    repeat (3) @(posedge pclk);
    chk_pin(comparator_irq, 1'b0, "global off");
    global_irq_enable <= 1'b1;
    repeat (3) @(posedge pclk);
    chk_pin(comparator_irq, 1'b1, "global on");
    wr(CSR_OFFSET, 8'h03);
    repeat (3) @(posedge pclk);
    chk_pin(comparator_irq, 1'b0, "enable off");
    wr(CSR_OFFSET, 8'h13);
    raw_to(1'b0);
    $display("test irq done");
  endtask : test_irq

  task automatic test_route;
    wr(CSR_OFFSET, 8'h04);
    raw_to(1'b1);
    chk_pin(capture_trigger, 1'b1, "capture high");
    raw_to(1'b0);
    chk_pin(capture_trigger, 1'b0, "capture low");
    wr(CSR_OFFSET, 8'h10);
    raw_to(1'b1);
    chk_pin(capture_trigger, 1'b0, "no route");
    raw_to(1'b0);
    wr(CSR_OFFSET, 8'h10);
    $display("test route done");
  endtask : test_route

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    test_reset();
    test_power();
    test_mux();
    test_modes();
    test_clear();
    test_irq();
    test_route();
    wrap_up();
  end
endmodule : tb

// ---- verilog/comparator_control.sv ----
// comparator control, status and event logic behind an apb slave
//
// Contract
// - raw comparator result is synchronised into read-only status bit 5.
// - power-off bit at one switches the comparator off, any time.
// - bandgap bit selects internal reference, else positive pin.
// - event matching selected mode sets the event flag.
// - flag clears on vector execution or on writing one to it.
// - irq only while flag, irq enable and global enable are one; here irq is registered and follows them one cycle late.
// - mode 00 toggle, 01 reserved, 10 falling, 11 rising edge.
// - capture-route bit connects output to timer capture trigger.
// - routed signal uses timer canceller, edge select and capture mask.
// - mux-enable bit is bit 6 of converter control b, read/write.
// - mux enabled, converter off: channel select picks channel 0 to 7.
// - mux disabled or converter on: negative pin feeds negative input.
//
// Our own choices: the address map and the APB slave port.
`timescale 1ns/100ps
module comparator_control (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [comparator_ctrl_pkg::ADDR_W-1:0] paddr,
  input wire logic [comparator_ctrl_pkg::DATA_W-1:0] pwdata,
  output logic [comparator_ctrl_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic comparator_raw,
  input wire logic global_irq_enable,
  input wire logic irq_vector_ack,
  output logic comparator_power_off,
  output logic bandgap_positive_select,
  output logic negative_use_channel,
  output logic [2:0] negative_channel,
  output logic capture_trigger,
  output logic comparator_irq
);
  import comparator_ctrl_pkg::*;

  // control state
  logic power_off_reg;
  logic bandgap_reg;
  logic flag_reg;
  logic irq_en_reg;
  logic route_reg;
  logic [1:0] mode_reg;
  logic mux_en_reg;
  logic conv_en_reg;
  logic [2:0] chan_reg;

  // registered outputs
  logic neg_use_reg;
  logic [2:0] neg_chan_reg;
  logic capture_reg;
  logic irq_reg;
  logic [DATA_W-1:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;

  // comparator path
  logic sync_level;
  logic edge_rise;
  logic edge_fall;
  logic edge_toggle;
  logic event_hit;

  // bus decode
  logic setup_phase;
  logic access_done;
  logic wr_access;
  logic csr_write;
  logic flag_clear;
  logic flag_next;
  logic [DATA_W-1:0] rd_word;

  function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
    is_mapped = (addr == CSR_OFFSET) || (addr == CTRL_B_OFFSET) ||
                (addr == MUX_OFFSET) || (addr == CTRL_A_OFFSET);
  endfunction : is_mapped

  function automatic logic wr_hit(input logic [ADDR_W-1:0] addr,
                                  input logic [ADDR_W-1:0] offset);
    wr_hit = (addr == offset);
  endfunction : wr_hit

  comparator_sync_edge u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .raw_in(comparator_raw),
    .level(sync_level),
    .rise(edge_rise),
    .fall(edge_fall),
    .toggle(edge_toggle)
  );

  // apb phases; every access completes in its first access cycle
  assign setup_phase = psel && !penable;
  assign access_done = psel && penable && pready_reg;
  assign wr_access = access_done && pwrite;
  assign csr_write = wr_access && wr_hit(paddr, CSR_OFFSET);

  // reserved mode code never produces an event
  always_comb begin
    case (mode_reg)
      MODE_TOGGLE: event_hit = edge_toggle;
      MODE_FALL: event_hit = edge_fall;
      MODE_RISE: event_hit = edge_rise;
      MODE_RESERVED: event_hit = 1'b0;
      default: event_hit = 1'b0;
    endcase
  end

  // clear by vector or by writing one; a same-cycle event wins
  assign flag_clear = irq_vector_ack ||
                      (csr_write && pwdata[FLAG_BIT]);
  assign flag_next = event_hit ? 1'b1 :
                     (flag_clear ? 1'b0 : flag_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg <= CSR_RESET[FLAG_BIT];
    end else begin
      flag_reg <= flag_next;
    end
  end

  // comparator_control_status writable fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_off_reg <= CSR_RESET[POWER_OFF_BIT];
      bandgap_reg <= CSR_RESET[BANDGAP_BIT];
      irq_en_reg <= CSR_RESET[IRQ_EN_BIT];
      route_reg <= CSR_RESET[ROUTE_BIT];
      mode_reg <= CSR_RESET[MODE_HI_BIT:MODE_LO_BIT];
    end else if (csr_write) begin
      // no guard against changing these with irq enabled; a spurious
      // event is then possible, as software is expected to avoid it
      power_off_reg <= pwdata[POWER_OFF_BIT];
      bandgap_reg <= pwdata[BANDGAP_BIT];
      irq_en_reg <= pwdata[IRQ_EN_BIT];
      route_reg <= pwdata[ROUTE_BIT];
      mode_reg <= pwdata[MODE_HI_BIT:MODE_LO_BIT];
    end
  end

  // converter registers shared with the multiplexer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mux_en_reg <= CTRL_B_RESET[MUX_EN_BIT];
      chan_reg <= MUX_RESET[CHAN_HI_BIT:CHAN_LO_BIT];
      conv_en_reg <= CTRL_A_RESET[CONV_EN_BIT];
    end else if (wr_access) begin
      if (wr_hit(paddr, CTRL_B_OFFSET)) begin
        mux_en_reg <= pwdata[MUX_EN_BIT];
      end
      if (wr_hit(paddr, MUX_OFFSET)) begin
        chan_reg <= pwdata[CHAN_HI_BIT:CHAN_LO_BIT];
      end
      if (wr_hit(paddr, CTRL_A_OFFSET)) begin
        conv_en_reg <= pwdata[CONV_EN_BIT];
      end
    end
  end

  // negative input selection; channel code is held even when unused
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      neg_use_reg <= 1'b0;
      neg_chan_reg <= 3'h0;
    end else begin
      neg_use_reg <= mux_en_reg && !conv_en_reg;
      neg_chan_reg <= chan_reg;
    end
  end

  // timer capture route; the timer applies its own canceller, edge
  // select and capture mask, so only the plain level is forwarded
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_reg <= 1'b0;
    end else begin
      capture_reg <= route_reg && sync_level;
    end
  end

  // interrupt request, registered: follows the flag by one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= flag_reg && irq_en_reg && global_irq_enable;
    end
  end

  // read word; unused upper bits read as zero
  always_comb begin
    rd_word = '0;
    case (paddr)
      CSR_OFFSET: begin
        rd_word[POWER_OFF_BIT] = power_off_reg;
        rd_word[BANDGAP_BIT] = bandgap_reg;
        rd_word[SYNC_OUT_BIT] = sync_level;
        rd_word[FLAG_BIT] = flag_reg;
        rd_word[IRQ_EN_BIT] = irq_en_reg;
        rd_word[ROUTE_BIT] = route_reg;
        rd_word[MODE_HI_BIT:MODE_LO_BIT] = mode_reg;
      end
      CTRL_B_OFFSET: begin
        rd_word[MUX_EN_BIT] = mux_en_reg;
      end
      MUX_OFFSET: begin
        rd_word[CHAN_HI_BIT:CHAN_LO_BIT] = chan_reg;
      end
      CTRL_A_OFFSET: begin
        rd_word[CONV_EN_BIT] = conv_en_reg;
      end
      default: rd_word = '0;
    endcase
  end

  // answer prepared in setup so that every output is a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= '0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= setup_phase;
      pslverr_reg <= setup_phase && !is_mapped(paddr);
      if (setup_phase && !pwrite) begin
        prdata_reg <= rd_word;
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign comparator_power_off = power_off_reg;
  assign bandgap_positive_select = bandgap_reg;
  assign negative_use_channel = neg_use_reg;
  assign negative_channel = neg_chan_reg;
  assign capture_trigger = capture_reg;
  assign comparator_irq = irq_reg;

  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);

  power_off_a: assert property (
    csr_write |=> comparator_power_off == $past(pwdata[POWER_OFF_BIT]))
    else $error("power-off output ignores write");

  bandgap_sel_a: assert property (
    csr_write |=> bandgap_positive_select == $past(pwdata[BANDGAP_BIT]))
    else $error("bandgap select ignores write");

  flag_set_a: assert property (
    event_hit |=> flag_reg ##1 (comparator_irq ==
      $past(irq_en_reg && global_irq_enable)))
    else $error("event did not set flag");

  flag_clear_a: assert property (
    (irq_vector_ack && !event_hit) |=> !flag_reg)
    else $error("vector did not clear flag");

  irq_gate_a: assert property (
    comparator_irq == $past(flag_reg && irq_en_reg && global_irq_enable))
    else $error("irq not gated by flag and enables");

  mode_reserved_a: assert property (
    (mode_reg == MODE_RESERVED && !flag_reg && !csr_write) |=> !flag_reg)
    else $error("reserved mode raised the flag");

  mode_rise_a: assert property (
    (mode_reg == MODE_RISE && edge_fall && !flag_reg) |=> !flag_reg)
    else $error("rising mode reacted to falling edge");

  capture_route_a: assert property (
    !route_reg ##1 !route_reg |-> !capture_trigger)
    else $error("capture trigger driven without route");

  mux_bit_a: assert property (
    (wr_access && wr_hit(paddr, CTRL_B_OFFSET)) |=>
      mux_en_reg == $past(pwdata[MUX_EN_BIT]))
    else $error("mux enable bit not written");

  neg_select_a: assert property (
    negative_use_channel == $past(mux_en_reg && !conv_en_reg))
    else $error("negative input select wrong");

  flag_wclr_a: assert property (
    (csr_write && pwdata[FLAG_BIT] && !event_hit) |=> !flag_reg)
    else $error("write of one did not clear flag");

  flag_hold_a: assert property (
    (!event_hit && !flag_clear) |=> flag_reg == $past(flag_reg))
    else $error("flag changed without event or clear");

  irq_enable_off_a: assert property (
    !irq_en_reg |=> !comparator_irq)
    else $error("irq raised with enable clear");

  mode_fall_a: assert property (
    (mode_reg == MODE_FALL && edge_rise && !flag_reg) |=> !flag_reg)
    else $error("falling mode reacted to rising edge");

  mode_toggle_a: assert property (
    (mode_reg == MODE_TOGGLE && edge_toggle) |=> flag_reg)
    else $error("toggle mode missed an edge");

  neg_pin_a: assert property (
    (!mux_en_reg || conv_en_reg) |=> !negative_use_channel)
    else $error("negative pin not selected");

  neg_chan_a: assert property (
    negative_channel == $past(chan_reg))
    else $error("negative channel code wrong");

  capture_follow_a: assert property (
    route_reg |=> capture_trigger == $past(sync_level))
    else $error("capture trigger does not follow output");

  status_bit_a: assert property (
    (setup_phase && !pwrite && paddr == CSR_OFFSET) |=>
      prdata[SYNC_OUT_BIT] == $past(sync_level))
    else $error("status bit does not show sync output");

  mux_read_a: assert property (
    (setup_phase && !pwrite && paddr == CTRL_B_OFFSET) |=>
      prdata[MUX_EN_BIT] == $past(mux_en_reg))
    else $error("mux enable bit does not read back");

  cover_flag_c: cover property (event_hit ##1 flag_reg);
  cover_irq_c: cover property (!comparator_irq ##1 comparator_irq);
  cover_chan_c: cover property (negative_use_channel &&
                                negative_channel == 3'h7);
  cover_capture_c: cover property (capture_trigger);
  cover_reserved_c: cover property (mode_reg == MODE_RESERVED && edge_toggle);

endmodule : comparator_control

// ---- verilog/comparator_ctrl_pkg.sv ----
// register map, field positions, reset values and codes of the comparator
package comparator_ctrl_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // register byte offsets
  localparam logic [11:0] CSR_OFFSET = 12'h000;
  localparam logic [11:0] CTRL_B_OFFSET = 12'h004;
  localparam logic [11:0] MUX_OFFSET = 12'h008;
  localparam logic [11:0] CTRL_A_OFFSET = 12'h00c;

  // comparator_control_status fields
  localparam int unsigned POWER_OFF_BIT = 7;
  localparam int unsigned BANDGAP_BIT = 6;
  localparam int unsigned SYNC_OUT_BIT = 5;
  localparam int unsigned FLAG_BIT = 4;
  localparam int unsigned IRQ_EN_BIT = 3;
  localparam int unsigned ROUTE_BIT = 2;
  localparam int unsigned MODE_HI_BIT = 1;
  localparam int unsigned MODE_LO_BIT = 0;

  // converter_control_b, converter_mux_register, converter_control_a
  localparam int unsigned MUX_EN_BIT = 6;
  localparam int unsigned CHAN_HI_BIT = 2;
  localparam int unsigned CHAN_LO_BIT = 0;
  localparam int unsigned CONV_EN_BIT = 7;

  // reset values
  localparam logic [7:0] CSR_RESET = 8'h00;
  localparam logic [7:0] CTRL_B_RESET = 8'h00;
  localparam logic [7:0] MUX_RESET = 8'h00;
  localparam logic [7:0] CTRL_A_RESET = 8'h00;

  // interrupt mode codes
  localparam logic [1:0] MODE_TOGGLE = 2'h0;
  localparam logic [1:0] MODE_RESERVED = 2'h1;
  localparam logic [1:0] MODE_FALL = 2'h2;
  localparam logic [1:0] MODE_RISE = 2'h3;

  // synchroniser latency in pclk edges
  localparam int unsigned SYNC_STAGES = 2;

endpackage : comparator_ctrl_pkg

// ---- verilog/comparator_sync_edge.sv ----
// two-stage synchroniser and edge detector for the comparator result
`timescale 1ns/100ps
module comparator_sync_edge (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic raw_in,
  output logic level,
  output logic rise,
  output logic fall,
  output logic toggle
);
  import comparator_ctrl_pkg::*;

  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  // first stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= raw_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign level = sync_reg;
  assign rise = sync_reg & ~prev_reg;
  assign fall = ~sync_reg & prev_reg;
  assign toggle = sync_reg ^ prev_reg;

  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);

  sync_delay_a: assert property (
    ##SYNC_STAGES level == $past(raw_in, SYNC_STAGES))
    else $error("sync output does not follow raw input");
  edge_pulse_a: assert property (
    rise |-> (level && !$past(level)) ##1 !rise)
    else $error("rise pulse not a single cycle edge");

endmodule : comparator_sync_edge
